// ===== src/jsl_pkg.sv
/*
 * Shared constants, carrier types and the 8b/10b symbol function for the
 * SYSREF alignment and lane packer of a dual-channel converter in wide-band mode.
 * Assumes a single 100 MHz system clock that stands in for the sample clock.
 */
package jsl_pkg;

    // Link geometry of the wide-band mode: eight lanes, two converters,
    // eight octets per frame, twenty samples per frame, sixteen frames per multiframe.
    localparam int JSL_NUM_CH = 2;
    localparam int JSL_LANES_PER_CH = 4;
    localparam int JSL_NUM_LANES = 8;
    localparam int JSL_OCTETS = 8;
    localparam int JSL_SMP_W = 12;
    localparam int JSL_SMP_PER_LANE = 5;
    localparam int JSL_PAD_W = 4;
    localparam int JSL_WORD_W = 64;
    localparam int JSL_SYM_W = 80;
    localparam int JSL_S_FRAME = 20;
    localparam int JSL_K_FRAMES = 16;
    localparam int JSL_CORE_DIV = 4;

    // Counter widths, last counts and values after reset.
    localparam int JSL_POS_W = 5;
    localparam int JSL_MF_W = 4;
    localparam logic [4:0] JSL_POS_LAST = 5'h13;
    localparam logic [3:0] JSL_MF_LAST = 4'hF;
    localparam logic [4:0] JSL_POS_RST = 5'h00;
    localparam logic [3:0] JSL_MF_RST = 4'h0;
    localparam logic [1:0] JSL_DIV4_RST = 2'h0;
    localparam logic [1:0] JSL_DIV4_LAST = 2'h3;
    localparam logic [7:0] JSL_DIV_RST = 8'h00;
    localparam logic [3:0] JSL_PAD = 4'h0;

    // 5b/6b and 3b/4b codes for negative running disparity, abcdei / fghj order.
    localparam logic [5:0] JSL_6B [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] JSL_4B [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    localparam logic [3:0] JSL_4B_ALT7 = 4'h7;

    typedef struct packed {
        logic [JSL_SMP_W-1:0] b;
        logic [JSL_SMP_W-1:0] a;
    } jsl_smp_t;

    typedef logic [JSL_NUM_LANES-1:0][JSL_SYM_W-1:0] jsl_sym_arr_t;

    typedef struct packed {
        logic mf_start;
        jsl_sym_arr_t sym;
    } jsl_frame_t;

    typedef enum logic [1:0] {
        JSL_SYNC_WAIT = 2'b00,
        JSL_SYNC_LOCK = 2'b01,
        JSL_SYNC_MANUAL = 2'b10
    } jsl_sync_t;

    // Encodes one octet; returns {running disparity after, abcdei, fghj}.
    function automatic logic [10:0] jsl_enc(input logic [7:0] d, input logic rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic rd1;
        logic u6;
        logic u4;
        logic alt;
        c6 = JSL_6B[d[4:0]];
        u6 = ($countones(c6) != 3);
        if (rd && (u6 || d[4:0] == 5'h07))
            c6 = ~c6;
        rd1 = rd ^ u6;
        c4 = JSL_4B[d[7:5]];
        alt = (d[7:5] == 3'h7) &&
              ((!rd1 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
               (rd1 && (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E)));
        if (alt)
            c4 = JSL_4B_ALT7;
        u4 = ($countones(c4) != 2);
        if (rd1 && (u4 || d[7:5] == 3'h3))
            c4 = ~c4;
        return {rd1 ^ u4, c6, c4};
    endfunction

endpackage

// ===== src/jsl_skid_buf.sv
/*
 * Two-entry buffer with valid and ready on both sides; the head word and
 * the ready toward the filler both come straight from flip-flops.
 * Assumes synchronous active-low reset already released on sys_clk.
 */
`timescale 1ns/100ps
module jsl_skid_buf #(
    parameter int W = 8
) (
    input wire logic sys_clk, // System clock.
    input wire logic rst_n, // Synchronised reset, active low.
    input wire logic clk_en, // Freezes all state while low.
    input wire logic [W-1:0] in_data, // Word offered by the filler.
    input wire logic in_valid, // Filler offers a word.
    output logic in_ready, // Room for one more word.
    output logic [W-1:0] out_data, // Head word.
    output logic out_valid, // Head word is valid.
    input wire logic out_ready // Drain takes the head word.
);
    logic [W-1:0] skid_q;
    logic skid_v_q;
    logic push;
    logic pop;
    logic head_free;

    // The second entry absorbs a push made while the drain stalls.
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign head_free = !out_valid || pop;

    // Head entry refills from the second entry first, so order is kept.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            out_valid <= 1'b0;
        else if (clk_en && head_free)
        begin
            out_valid <= skid_v_q || push;
            if (skid_v_q)
                out_data <= skid_q;
            else if (push)
                out_data <= in_data;
        end
    end

    // Second entry and the registered ready that it implies.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            skid_v_q <= 1'b0;
            in_ready <= 1'b0;
        end
        else if (clk_en)
        begin
            if (push && (skid_v_q || !head_free))
            begin
                skid_q <= in_data;
                skid_v_q <= 1'b1;
                in_ready <= 1'b0;
            end
            else if (head_free)
            begin
                skid_v_q <= 1'b0;
                in_ready <= 1'b1;
            end
        end
    end

endmodule // jsl_skid_buf

// ===== src/jsl_lane_packer.sv
/*
 * SYSREF capture, divider and multiframe alignment, and the wide-band lane
 * packer with 8b/10b encoding for two 12-bit channels on eight lanes.
 * Assumes sys_clk stands in for the sample clock, one sample per channel
 * per accepted cycle; sysref_pin and arst_n are asynchronous, all other inputs are
 * synchronous to sys_clk.
 */
// Functional notes
// R1 - Subclass 1: sample SYSREF on device clock, align multiframe boundary to it.
// R2 - Bypass: SYSREF event resets divide-by-4, interleave dividers and LMFC.
// R3 - Decimation mode: event also resets decimator clock and NCO phase.
// R4 - After link-up in decimation mode, SYSREF is gated externally or internally.
// R5 - Controller supplies SYSREF before any configuration is loaded.
// R6 - Subclass 0: register-write trigger replaces SYSREF, latency not deterministic.
// R7 - Each lane packs five 12-bit samples plus four zero bits, 64 bits.
// R8 - Each 64-bit lane word passes 8b/10b encoding, 80 line bits.
// R9 - Word is MSB first; nibbles share octets; last octet ends 0000.
// R10 - Twenty samples per channel over four lanes, five consecutive per lane.
// R11 - Link is eight lanes, two converters, eight octets, twenty samples, K 16.
// R12 - K counts frames per multiframe; F counts octets per lane per frame.
// R13 - Local multiframe clock is frame clock divided by K.
// R14 - SYSREF period is an integer multiple of the multiframe period.
// R15 - SYSREF rate is sample clock over LCM(64, 20K) over an integer.
// R16 - Subclass 0: pulse, configure, mask dividers, pulse again for LMFC.
// R17 - Event is a rising sampled edge; only the first one restarts.
// R18 - Valid event restarts lane word assembly at sample 0.
`timescale 1ns/100ps
module jsl_lane_packer
    import jsl_pkg::*;
#(
    parameter int IL_DIV = 8,
    parameter int DEC_DIV = 8,
    parameter int FCW_W = 16
) (
    input wire logic sys_clk, // System clock, 100 MHz.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic clk_en, // Freezes all state except the reset synchroniser while low.
    input wire logic sysref_pin, // SYSREF strobe from the board.
    input wire logic subclass1, // High selects SYSREF, low the manual trigger.
    input wire logic ddc_mode, // High selects decimation mode.
    input wire logic sysref_gate, // Internal mask for external strobes.
    input wire logic div_mask, // Keeps triggers away from the core and interleave dividers.
    input wire logic manual_trig, // One-cycle trigger from register writes.
    input wire logic [FCW_W-1:0] nco_fcw, // Oscillator frequency word.
    input wire jsl_pkg::jsl_smp_t smp_in, // One sample of each channel.
    input wire logic smp_valid, // Sample pair offered.
    output logic smp_ready, // Sample pair taken when valid.
    output jsl_pkg::jsl_frame_t lane_out, // Eight encoded lane symbols.
    output logic lane_valid, // Encoded frame is valid.
    input wire logic lane_ready, // Receiver takes the frame.
    output logic [1:0] div4_phase, // Phase of the core divider.
    output logic [7:0] il_phase, // Phase of the interleave divider.
    output logic [7:0] dec_phase, // Phase of the decimator clock.
    output logic [FCW_W-1:0] nco_phase, // Oscillator phase.
    output logic lmfc_pulse, // One cycle at each multiframe end.
    output jsl_pkg::jsl_sync_t sync_state // Alignment status.
);
    import jsl_pkg::*;

    logic rst_s1;
    logic rst_n;
    logic sr_s1;
    logic sr_s2;
    logic sr_s3;
    logic sr_edge;
    logic ext_evt;
    logic man_evt;
    logic evt;
    logic div_rst;
    logic [JSL_POS_W-1:0] pos_q;
    logic [JSL_MF_W-1:0] mf_q;
    jsl_smp_t col_q [JSL_S_FRAME-1];
    jsl_smp_t frm [JSL_S_FRAME];
    logic [JSL_NUM_LANES-1:0][JSL_WORD_W-1:0] pw;
    logic [JSL_NUM_LANES-1:0] rd_q;
    logic [JSL_NUM_LANES-1:0] rd_d;
    jsl_frame_t frame_d;
    logic acc;
    logic push;
    logic fill_ready;

    // Reset enters asynchronously and is released through two flops.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Two flops take the strobe into the clock domain; the third is for edges.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            sr_s1 <= 1'b0;
            sr_s2 <= 1'b0;
            sr_s3 <= 1'b0;
        end
        else if (clk_en)
        begin
            sr_s1 <= sysref_pin; // R1
            sr_s2 <= sr_s1;
            sr_s3 <= sr_s2;
        end
    end

    // A strobe counts only as a rising edge, only once, and not while masked.
    // Repeated strobes would otherwise disturb the oscillator phase.
    assign sr_edge = sr_s2 && !sr_s3; // R17
    assign ext_evt = subclass1 && sr_edge && !sysref_gate &&
                     (sync_state == JSL_SYNC_WAIT); // R4 R17
    assign man_evt = !subclass1 && manual_trig; // R6
    assign evt = ext_evt || man_evt;
    assign div_rst = evt && !div_mask; // R16

    // Alignment status: waits for the first event, then holds; the manual state returns to waiting once subclass1 is high.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            sync_state <= JSL_SYNC_WAIT;
        else if (clk_en)
        begin
            unique case (sync_state)
                JSL_SYNC_WAIT:
                begin
                    if (ext_evt)
                        sync_state <= JSL_SYNC_LOCK; // R1
                    else if (man_evt)
                        sync_state <= JSL_SYNC_MANUAL; // R6
                end
                JSL_SYNC_LOCK:
                    sync_state <= JSL_SYNC_LOCK;
                JSL_SYNC_MANUAL:
                begin
                    if (subclass1)
                        sync_state <= JSL_SYNC_WAIT;
                end
                default:
                    sync_state <= JSL_SYNC_WAIT;
            endcase
        end
    end

    // Core and interleave dividers restart together on an unmasked event.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            div4_phase <= JSL_DIV4_RST;
            il_phase <= JSL_DIV_RST;
        end
        else if (clk_en)
        begin
            if (div_rst)
            begin
                div4_phase <= JSL_DIV4_RST; // R2
                il_phase <= JSL_DIV_RST; // R2
            end
            else
            begin
                div4_phase <= div4_phase + 2'h1;
                il_phase <= (il_phase == 8'(IL_DIV - 1)) ? JSL_DIV_RST : il_phase + 8'h01;
            end
        end
    end

    // Decimator clock and oscillator restart only in decimation mode.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            dec_phase <= JSL_DIV_RST;
            nco_phase <= '0;
        end
        else if (clk_en)
        begin
            if (evt && ddc_mode)
            begin
                dec_phase <= JSL_DIV_RST; // R3
                nco_phase <= '0; // R3
            end
            else
            begin
                dec_phase <= (dec_phase == 8'(DEC_DIV - 1)) ? JSL_DIV_RST : dec_phase + 8'h01;
                nco_phase <= nco_phase + nco_fcw;
            end
        end
    end

    // Sample acceptance; the buffer's ready stalls the source directly.
    assign smp_ready = fill_ready;
    assign acc = smp_valid && fill_ready && clk_en;
    assign push = acc && !evt && (pos_q == JSL_POS_LAST); // R11

    // Frame position is the frame clock, sample clock over twenty.
    // Multiframe count divides frames by K.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            pos_q <= JSL_POS_RST;
            mf_q <= JSL_MF_RST;
            lmfc_pulse <= 1'b0;
        end
        else if (clk_en)
        begin
            lmfc_pulse <= push && (mf_q == JSL_MF_LAST); // R13
            if (evt)
            begin
                pos_q <= JSL_POS_RST; // R18
                mf_q <= JSL_MF_RST; // R1 R2
            end
            else if (acc)
            begin
                pos_q <= (pos_q == JSL_POS_LAST) ? JSL_POS_RST : pos_q + 5'h01; // R11
                if (pos_q == JSL_POS_LAST)
                    mf_q <= mf_q + 4'h1; // R12 R13
            end
        end
    end

    // Collects the first nineteen pairs; the twentieth goes straight to the encoder.
    always_ff @(posedge sys_clk)
    begin
        if (acc && !evt && pos_q != JSL_POS_LAST)
            col_q[pos_q] <= smp_in;
    end

    // Assembles the frame: lane words, then 8b/10b with per-lane disparity.
    always_comb
    begin
        logic [10:0] enc;
        logic rd;
        enc = '0;
        rd = 1'b0;
        for (int i = 0; i < JSL_S_FRAME - 1; i++)
            frm[i] = col_q[i];
        frm[JSL_S_FRAME-1] = smp_in;
        frame_d.mf_start = (mf_q == JSL_MF_RST);
        for (int l = 0; l < JSL_LANES_PER_CH; l++)
        begin
            pw[l] = {frm[5*l].a, frm[5*l+1].a, frm[5*l+2].a,
                     frm[5*l+3].a, frm[5*l+4].a, JSL_PAD}; // R7 R9 R10
            pw[l+JSL_LANES_PER_CH] = {frm[5*l].b, frm[5*l+1].b, frm[5*l+2].b,
                                      frm[5*l+3].b, frm[5*l+4].b, JSL_PAD}; // R7 R10
        end
        for (int l = 0; l < JSL_NUM_LANES; l++)
        begin
            rd = rd_q[l];
            for (int o = 0; o < JSL_OCTETS; o++)
            begin
                enc = jsl_enc(pw[l][JSL_WORD_W-1-8*o -: 8], rd); // R8
                frame_d.sym[l][JSL_SYM_W-1-10*o -: 10] = enc[9:0]; // R9
                rd = enc[10];
            end
            rd_d[l] = rd;
        end
    end

    // Running disparity carries over from frame to frame on each lane.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            rd_q <= '0;
        else if (push)
            rd_q <= rd_d; // R8
    end

    // A stalled receiver loses no frame: the buffer holds two.
    jsl_skid_buf #(
        .W($bits(jsl_frame_t))
    ) u_buf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_data(frame_d),
        .in_valid(push),
        .in_ready(fill_ready),
        .out_data(lane_out),
        .out_valid(lane_valid),
        .out_ready(lane_ready)
    );

    a_edge_align: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
        clk_en && ext_evt |=> pos_q == JSL_POS_RST && mf_q == JSL_MF_RST
            && sync_state == JSL_SYNC_LOCK)
        else $error("Multiframe not aligned after strobe.");
    a_div_restart: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
        clk_en && div_rst |=> div4_phase == JSL_DIV4_RST && il_phase == JSL_DIV_RST
            ##1 (!clk_en || div_rst || div4_phase == 2'h1))
        else $error("Dividers did not restart.");
    a_ddc_restart: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
        clk_en && evt && ddc_mode |=> dec_phase == JSL_DIV_RST && nco_phase == '0)
        else $error("Decimator or oscillator not reset.");
    a_gate_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
        clk_en && subclass1 && sysref_gate && sync_state == JSL_SYNC_WAIT
            |=> sync_state == JSL_SYNC_WAIT)
        else $error("Masked strobe was taken.");
    a_manual_trig: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
        clk_en && !subclass1 && manual_trig |=> pos_q == JSL_POS_RST && mf_q == JSL_MF_RST)
        else $error("Manual trigger ignored.");
    a_lane_pack: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7 R9 R10
        push |-> pw[1][63:52] == frm[5].a && pw[7][15:4] == frm[19].b
            && pw[0][3:0] == JSL_PAD && pw[4][51:48] == frm[1].b[11:8])
        else $error("Lane word packing wrong.");
    a_sym_balance: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
        lane_valid |-> $countones(lane_out.sym[3][9:0]) inside {4, 5, 6}
            && $countones(lane_out.sym[6][79:70]) inside {4, 5, 6})
        else $error("Symbol disparity out of range.");
    a_frame_len: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
        push |-> pos_q == JSL_POS_LAST ##1 (pos_q == JSL_POS_RST || $past(evt)))
        else $error("Frame length is not twenty.");
    a_mf_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
        push && mf_q == JSL_MF_LAST |=> mf_q == JSL_MF_RST && lmfc_pulse)
        else $error("Multiframe did not wrap after K frames.");
    a_first_only: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
        sync_state == JSL_SYNC_LOCK |-> !ext_evt)
        else $error("Later strobe restarted the counters.");
    a_hold_stall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lane_valid && !lane_ready |=> lane_valid && $stable(lane_out))
        else $error("Stalled frame changed.");

    c_lock: cover property (@(posedge sys_clk) disable iff (!rst_n)
        ext_evt ##[1:100] push);
    c_stall_full: cover property (@(posedge sys_clk) disable iff (!rst_n)
        lane_valid && !lane_ready && !fill_ready);
    c_mf_end: cover property (@(posedge sys_clk) disable iff (!rst_n) lmfc_pulse);
    c_manual: cover property (@(posedge sys_clk) disable iff (!rst_n)
        man_evt && div_mask);

endmodule // jsl_lane_packer

// ===== tb/jsl_rx_model.sv
/*
 * Receiver model for the eight encoded lanes; it queues every frame it takes.
 * Assumes it shares sys_clk with the packer and sees the packer's lane outputs.
 */
`timescale 1ns/100ps
module jsl_rx_model (
    input wire logic sys_clk, // System clock.
    input wire logic arst_n, // Reset, active low.
    input wire logic slow, // When high, takes one frame in 32 cycles.
    input wire jsl_pkg::jsl_frame_t lane_out, // Encoded frame.
    input wire logic lane_valid, // Frame offered.
    output logic lane_ready // Frame taken.
);
    import jsl_pkg::*;
    jsl_frame_t got_q[$];
    logic [4:0] gap_q;
    // Frames are taken whole, so a slow receiver stalls but never splits one.
    always @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lane_ready <= 1'b0;
            gap_q <= 5'h00;
        end
        else
        begin
            if (lane_valid && lane_ready)
                got_q.push_back(lane_out);
            gap_q <= gap_q + 5'h01;
            lane_ready <= !slow || gap_q == 5'h1F;
        end
    end
endmodule // jsl_rx_model

// ===== tb/jsl_lane_packer_tb_top.sv
/*
 * Self-checking bench for the SYSREF alignment and lane packer.
 * Assumes the design package and the receiver model are compiled first.
 */
`timescale 1ns/100ps
module jsl_lane_packer_tb_top;
    import jsl_pkg::*;
    logic sys_clk, arst_n, sysref_pin, subclass1, ddc_mode, sysref_gate, div_mask;
    logic manual_trig, smp_valid, smp_ready, lane_valid, lane_ready, lmfc_pulse, slow;
    logic [15:0] nco_fcw, nco_phase;
    logic [1:0] div4_phase;
    logic [7:0] il_phase, dec_phase, rd_q;
    jsl_smp_t smp_in;
    jsl_frame_t lane_out;
    jsl_sync_t sync_state;
    jsl_frame_t exp_q[$];
    int n_mismatch, n_tests, n_lmfc, n_refused, n_frame;
    time t_lock;

    jsl_lane_packer dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(1'b1),
        .sysref_pin(sysref_pin), .subclass1(subclass1), .ddc_mode(ddc_mode),
        .sysref_gate(sysref_gate), .div_mask(div_mask), .manual_trig(manual_trig),
        .nco_fcw(nco_fcw), .smp_in(smp_in), .smp_valid(smp_valid), .smp_ready(smp_ready),
        .lane_out(lane_out), .lane_valid(lane_valid), .lane_ready(lane_ready),
        .div4_phase(div4_phase), .il_phase(il_phase), .dec_phase(dec_phase),
        .nco_phase(nco_phase), .lmfc_pulse(lmfc_pulse), .sync_state(sync_state));
    jsl_rx_model rx (.sys_clk(sys_clk), .arst_n(arst_n), .slow(slow), .lane_out(lane_out),
        .lane_valid(lane_valid), .lane_ready(lane_ready));

    // Free-running 100 MHz clock.
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Counts multiframe pulses and refused sample offers.
    always @(posedge sys_clk)
    begin
        if (lmfc_pulse === 1'b1)
            n_lmfc++;
        if (smp_valid && smp_ready === 1'b0)
            n_refused++;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic timed_out(input string what);
        n_mismatch++;
        $display("wrong value %s expected done seen timeout", what);
        finish_test();
    endtask

    // Own 8b/10b reference from the code tables; returns {disparity, abcdei, fghj}.
    function automatic logic [10:0] enc8(input logic [7:0] d, input logic rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic r;
        c6 = JSL_6B[d[4:0]];
        r = rd;
        if ($countones(c6) != 3)
        begin
            c6 = rd ? ~c6 : c6;
            r = ~rd;
        end
        else if (rd && d[4:0] == 5'h07)
            c6 = ~c6;
        c4 = JSL_4B[d[7:5]];
        if (d[7:5] == 3'h7 && ((!r && d[4:0] inside {5'h11, 5'h12, 5'h14}) ||
            (r && d[4:0] inside {5'h0B, 5'h0D, 5'h0E})))
            c4 = JSL_4B_ALT7;
        if ($countones(c4) != 2)
        begin
            c4 = r ? ~c4 : c4;
            r = ~r;
        end
        else if (r && d[7:5] == 3'h3)
            c4 = ~c4;
        return {r, c6, c4};
    endfunction

    // Holds the pair until the edge that takes it; the caller releases valid.
    task automatic send_pair(input logic [11:0] a, input logic [11:0] b);
        smp_in <= '{b: b, a: a};
        smp_valid <= 1'b1;
        repeat (300)
        begin
            @(posedge sys_clk);
            if (smp_ready === 1'b1)
                return;
        end
        timed_out("sample accept");
    endtask

    // Builds the expected frame from twenty pairs, then sends them.
    task automatic send_frame(input int f);
        logic [11:0] s [2][20];
        logic [63:0] w;
        logic [10:0] c;
        jsl_frame_t e;
        int m;
        for (int i = 0; i < 20; i++)
        begin
            s[0][i] = 12'(i * 12'h0CD + f * 12'h111);
            s[1][i] = ~s[0][i];
        end
        for (int l = 0; l < 8; l++)
        begin
            m = 5 * (l % 4);
            w = {s[l/4][m], s[l/4][m+1], s[l/4][m+2], s[l/4][m+3], s[l/4][m+4], JSL_PAD};
            for (int o = 0; o < 8; o++)
            begin
                c = enc8(w[63-8*o -: 8], rd_q[l]);
                e.sym[l][79-10*o -: 10] = c[9:0];
                rd_q[l] = c[10];
            end
        end
        e.mf_start = (n_frame % 16 == 0);
        n_frame++;
        exp_q.push_back(e);
        for (int i = 0; i < 20; i++)
            send_pair(s[0][i], s[1][i]);
    endtask

    task automatic check_frames(input int n);
        jsl_frame_t g;
        jsl_frame_t e;
        repeat (3000)
            if (rx.got_q.size() < n)
                @(posedge sys_clk);
        if (rx.got_q.size() < n)
            timed_out("frames received");
        repeat (n)
        begin
            g = rx.got_q.pop_front();
            e = exp_q.pop_front();
            chk("frame start", e.mf_start, g.mf_start);
            for (int l = 0; l < 8; l++)
                chk("lane symbols", e.sym[l], g.sym[l]);
        end
    endtask

    // Pulses the manual trigger and waits for the oscillator phase to clear.
    task automatic trig(input logic mask);
        int c;
        manual_trig <= 1'b1;
        div_mask <= mask;
        @(posedge sys_clk);
        manual_trig <= 1'b0;
        for (c = 0; c < 6 && nco_phase !== 16'h0000; c++)
            @(posedge sys_clk);
        if (c == 6)
            timed_out("manual trigger");
        chk("state", JSL_SYNC_MANUAL, sync_state);
        chk("dec phase", 8'h00, dec_phase);
        c = int'(($time - t_lock) / 10);
        chk("div4 phase", mask ? 2'(c % 4) : 2'h0, div4_phase);
        chk("il phase", mask ? 8'(c % 8) : 8'h00, il_phase);
        if (!mask)
            t_lock = $time;
    endtask

    task automatic t_lock_run;
        int c;
        sysref_gate <= 1'b1;
        sysref_pin <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk("gated state", JSL_SYNC_WAIT, sync_state);
        sysref_pin <= 1'b0;
        sysref_gate <= 1'b0;
        repeat (4) @(posedge sys_clk);
        sysref_pin <= 1'b1;
        for (c = 0; c < 10 && sync_state !== JSL_SYNC_LOCK; c++)
            @(posedge sys_clk);
        if (c == 10)
            timed_out("lock");
        t_lock = $time;
        chk("div4 phase", 2'h0, div4_phase);
        chk("il phase", 8'h00, il_phase);
        chk("dec phase", 8'h00, dec_phase);
        chk("nco phase", 16'h0000, nco_phase);
        sysref_pin <= 1'b0;
        nco_fcw <= 16'h1234;
        $display("test lock done");
    endtask

    // Sixteen frames through a slow receiver, with a late strobe mid-stream.
    task automatic t_stream;
        slow <= 1'b1;
        for (int f = 0; f < 16; f++)
        begin
            send_frame(f);
            sysref_pin <= (f == 5);
        end
        smp_valid <= 1'b0;
        check_frames(16);
        chk("lmfc pulses", 1, n_lmfc);
        chk("refusals seen", 1, n_refused > 0);
        chk("state", JSL_SYNC_LOCK, sync_state);
        slow <= 1'b0;
        $display("test stream done");
    endtask

    // Manual sequence; a partial frame is dropped at the second trigger.
    // A lock holds until reset, so the manual mode starts from a fresh reset.
    task automatic t_manual;
        arst_n <= 1'b0;
        subclass1 <= 1'b0;
        rd_q = 8'h00;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("state after reset", JSL_SYNC_WAIT, sync_state);
        trig(1'b0);
        for (int i = 0; i < 7; i++)
            send_pair(12'hFFF, 12'h000);
        smp_valid <= 1'b0;
        trig(1'b1);
        n_frame = 0;
        send_frame(16);
        smp_valid <= 1'b0;
        check_frames(1);
        $display("test manual done");
    endtask

    // Main sequence: reset, then each scenario in turn.
    initial
    begin
        {arst_n, sysref_pin, sysref_gate, div_mask, manual_trig, smp_valid, slow} = '0;
        {subclass1, ddc_mode} = 2'b11;
        nco_fcw = 16'h0000;
        smp_in = '0;
        rd_q = 8'h00;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("reset state", JSL_SYNC_WAIT, sync_state);
        chk("reset lane valid", 1'b0, lane_valid);
        t_lock_run();
        t_stream();
        t_manual();
        finish_test();
    end
endmodule // jsl_lane_packer_tb_top
